// [pkg/mdu_defines.svh]
`ifndef MDU_DEFINES_SVH
`define MDU_DEFINES_SVH

// ************************************************************
// register offsets on the special function register bus
// ************************************************************
`define MDU_ADDR_BYTE0 8'hE9
`define MDU_ADDR_BYTE1 8'hEA
`define MDU_ADDR_BYTE2 8'hEB
`define MDU_ADDR_BYTE3 8'hEC
`define MDU_ADDR_BYTE4 8'hED
`define MDU_ADDR_BYTE5 8'hEE
`define MDU_ADDR_CTRL 8'hEF

// ************************************************************
// control/status fields and reset values
// ************************************************************
`define MDU_CTRL_ERR_BIT 7
`define MDU_CTRL_OV_BIT 6
`define MDU_CTRL_DIR_BIT 5
`define MDU_CTRL_CNT_MSB 4
`define MDU_CTRL_RESET 8'h00
`define MDU_BYTE_RESET 8'h00

// ************************************************************
// execution lengths in core clock cycles
// ************************************************************
`define MDU_CYC_DIV32 5'h11
`define MDU_CYC_DIV16 5'h09
`define MDU_CYC_MUL 5'h0B
`define MDU_CYC_SHIFT_MIN 5'h03
`define MDU_CYC_NORM_MIN 5'h04
`define MDU_CYC_NORM_MAX 5'h13

`endif

// [pkg/mdu_pkg.sv]
`default_nettype none

package mdu_pkg;

	typedef enum logic [2:0] {
		op_none,
		op_div32,
		op_div16,
		op_mul,
		op_shift,
		op_norm
	} op_t;

	typedef struct packed {
		logic [5:0][7:0] md;
		logic err;
		logic ov;
		logic dir;
		logic [4:0] cnt;
		logic armed;
		logic busy;
		op_t op;
		logic [4:0] left;
		logic seen23;
		logic last_mul;
		logic [7:0] rdata;
	} state_t;

endpackage

`default_nettype wire

// [design/mul_div_unit.sv]
`timescale 1ns/100ps
`default_nettype none

module mul_div_unit (
	input wire mdu_pkg::op_t op_in,
	input wire logic [47:0] md_in,
	output logic [47:0] md_out,
	output logic ov_out
);

	logic [31:0] dividend32;
	logic [15:0] divisor;
	logic [31:0] product;

	// unsigned operands only; the bytes are overwritten by the results
	assign dividend32 = md_in[31:0];
	assign divisor = md_in[47:32];
	assign product = {16'h0000, md_in[15:0]} * {16'h0000, divisor};

	always_comb begin
		md_out = md_in;
		ov_out = 1'b0;
		unique case (op_in)
			mdu_pkg::op_div32: begin
				if (divisor == 16'h0000) begin
					ov_out = 1'b1;
					md_out[31:0] = 32'hFFFFFFFF;
					md_out[47:32] = dividend32[15:0];
				end else begin
					md_out[31:0] = dividend32 / {16'h0000, divisor};
					md_out[47:32] = 16'(dividend32 % {16'h0000, divisor});
				end
			end
			mdu_pkg::op_div16: begin
				if (divisor == 16'h0000) begin
					ov_out = 1'b1;
					md_out[15:0] = 16'hFFFF;
					md_out[47:32] = md_in[15:0];
				end else begin
					md_out[15:0] = md_in[15:0] / divisor;
					md_out[47:32] = md_in[15:0] % divisor;
				end
			end
			mdu_pkg::op_mul: begin
				md_out[31:0] = product;
				ov_out = (product[31:16] != 16'h0000);
			end
			default: begin
				md_out = md_in;
			end
		endcase
	end

endmodule // mul_div_unit

`default_nettype wire

// [design/shift_norm_unit.sv]
`timescale 1ns/100ps
`default_nettype none

module shift_norm_unit (
	input wire logic [31:0] value_in,
	input wire logic dir_in,
	input wire logic [4:0] count_in,
	output logic [31:0] value_out,
	output logic [4:0] lead_zero_out,
	output logic top_set_out
);

	logic [4:0] lz;

	// a zero value saturates at the largest count the field can hold
	always_comb begin
		lz = 5'h1F;
		for (int i = 0; i < 32; i++) begin
			if (value_in[i]) begin
				lz = 5'(31 - i);
			end
		end
	end

	always_comb begin
		if (count_in == 5'h00) begin
			value_out = value_in << lz;
		end else if (dir_in) begin
			value_out = value_in >> count_in;
		end else begin
			value_out = value_in << count_in;
		end
	end

	assign lead_zero_out = lz;
	assign top_set_out = value_in[31];

endmodule // shift_norm_unit

`default_nettype wire

// [design/arith_coprocessor.sv]
// Notes on behaviour
// - operation starts on operand_byte5 write, or control write for shift/normalize
// - byte2 or byte3 written between byte0 and byte5 selects 32/16 division
// - otherwise last of byte4 (16/16 divide) or byte1 (16x16 multiply) decides
// - control bit 5 picks shift direction: 0 left, 1 right
// - count field bits 4..0: zero means normalize, nonzero shifts that many places
// - 32/16 divide takes 17 cycles, 16/16 divide 9, multiply 11
// - shift takes 3 to 18 cycles, normalize 4 to 19, scaling with count
// - execution runs alone; the core is never stalled
// - result bytes read in any order; reading byte5 (divide) or byte3 (other operations) ends the job
// - normalize shifts left until byte3 top bit is one, stores shift count
// - shifts bring zeros in at byte3 top or byte0 bottom
// - error detection arms on byte0 write, disarms on final result read
// - any operand or control write during execution sets the error flag
// - operand read during armed execution sets error; calculation still completes
// - error flag is read only and clears only on control register read
// - overflow on divide by zero, product above FFFFh, normalize of top-set value
// - other operations clear overflow; core writes never touch it
// - all arithmetic is unsigned
// - results overwrite the operand bytes
`timescale 1ns/100ps
`default_nettype none
`include "mdu_defines.svh"

module arith_coprocessor (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic sfr_rd_in,
	input wire logic [7:0] sfr_wdata_in,
	output logic [7:0] sfr_rdata_out,
	output logic busy_out
);

	// ************************************************************
	// state and decode
	// ************************************************************
	mdu_pkg::state_t st;
	mdu_pkg::state_t next_st;

	logic is_md;
	logic is_ctrl;
	logic [2:0] idx;
	logic [47:0] md_res;
	logic md_ov;
	logic [31:0] sn_value;
	logic [4:0] sn_lz;
	logic sn_top;
	logic [4:0] shift_cycles;
	logic [4:0] norm_cycles;
	logic [4:0] run_cnt;

	assign is_md = (sfr_addr_in >= `MDU_ADDR_BYTE0) && (sfr_addr_in <= `MDU_ADDR_BYTE5);
	assign is_ctrl = (sfr_addr_in == `MDU_ADDR_CTRL);
	assign idx = 3'(sfr_addr_in - `MDU_ADDR_BYTE0);

	// ************************************************************
	// arithmetic datapaths
	// ************************************************************
	mul_div_unit u_mul_div (
		.op_in(st.op),
		.md_in(st.md),
		.md_out(md_res),
		.ov_out(md_ov)
	);

	shift_norm_unit u_shift_norm (
		.value_in(st.md[3:0]),
		.dir_in(st.dir),
		.count_in(st.cnt),
		.value_out(sn_value),
		.lead_zero_out(sn_lz),
		.top_set_out(sn_top)
	);

	// the length follows the count; normalize length depends on the value already held
	assign shift_cycles = `MDU_CYC_SHIFT_MIN + ((sfr_wdata_in[4:0] - 5'h01) >> 1);
	assign norm_cycles = (sn_lz == 5'h00) ? `MDU_CYC_NORM_MIN :
		(`MDU_CYC_NORM_MIN + ((sn_lz - 5'h01) >> 1));

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		next_st = st;

		// error flag clears on control read; any set further down wins
		if (sfr_rd_in && is_ctrl) begin
			next_st.err = 1'b0;
		end

		// execution countdown, independent of the core
		if (st.busy) begin
			if (st.left == 5'h00) begin
				next_st.busy = 1'b0;
				unique case (st.op)
					mdu_pkg::op_div32, mdu_pkg::op_div16, mdu_pkg::op_mul: begin
						next_st.md = md_res;
						next_st.ov = md_ov;
					end
					mdu_pkg::op_shift: begin
						next_st.md[3:0] = sn_value;
						next_st.ov = 1'b0;
					end
					mdu_pkg::op_norm: begin
						next_st.md[3:0] = sn_value;
						next_st.cnt = sn_lz;
						next_st.ov = sn_top;
					end
					mdu_pkg::op_none: begin
						next_st.busy = 1'b0;
					end
				endcase
			end else begin
				next_st.left = st.left - 5'h01;
			end
		end

		// operand byte writes steer the operation choice
		if (sfr_wr_in && is_md) begin
			next_st.md[idx] = sfr_wdata_in;
			if (st.busy) begin
				next_st.err = 1'b1;
			end
			unique case (idx)
				3'h0: begin
					next_st.armed = 1'b1;
					next_st.seen23 = 1'b0;
					next_st.last_mul = 1'b0;
				end
				3'h1: begin
					next_st.last_mul = 1'b1;
				end
				3'h2, 3'h3: begin
					next_st.seen23 = 1'b1;
				end
				3'h4: begin
					next_st.last_mul = 1'b0;
				end
				3'h5: begin
					next_st.busy = 1'b1;
					if (st.seen23) begin
						next_st.op = mdu_pkg::op_div32;
						next_st.left = `MDU_CYC_DIV32 - 5'h01;
					end else if (st.last_mul) begin
						next_st.op = mdu_pkg::op_mul;
						next_st.left = `MDU_CYC_MUL - 5'h01;
					end else begin
						next_st.op = mdu_pkg::op_div16;
						next_st.left = `MDU_CYC_DIV16 - 5'h01;
					end
				end
				default: begin
					next_st.seen23 = st.seen23;
				end
			endcase
		end

		// control write: direction and count only, both flags stay hardware owned
		if (sfr_wr_in && is_ctrl) begin
			next_st.dir = sfr_wdata_in[`MDU_CTRL_DIR_BIT];
			next_st.cnt = sfr_wdata_in[`MDU_CTRL_CNT_MSB:0];
			next_st.busy = 1'b1;
			if (st.busy) begin
				next_st.err = 1'b1;
			end
			if (sfr_wdata_in[`MDU_CTRL_CNT_MSB:0] == 5'h00) begin
				next_st.op = mdu_pkg::op_norm;
				next_st.left = norm_cycles - 5'h01;
			end else begin
				next_st.op = mdu_pkg::op_shift;
				next_st.left = shift_cycles - 5'h01;
			end
		end

		// reads: data is registered one cycle behind the strobe
		if (sfr_rd_in) begin
			if (is_md) begin
				next_st.rdata = st.md[idx];
				if (st.busy && st.armed) begin
					next_st.err = 1'b1;
				end
				if (!st.busy && st.armed) begin
					unique case (st.op)
						mdu_pkg::op_div32, mdu_pkg::op_div16: begin
							if (idx == 3'h5) begin
								next_st.armed = 1'b0;
							end
						end
						mdu_pkg::op_mul, mdu_pkg::op_shift, mdu_pkg::op_norm: begin
							if (idx == 3'h3) begin
								next_st.armed = 1'b0;
							end
						end
						mdu_pkg::op_none: begin
							next_st.armed = st.armed;
						end
					endcase
				end
			end else if (is_ctrl) begin
				next_st.rdata = {st.err, st.ov, st.dir, st.cnt};
			end else begin
				next_st.rdata = 8'h00;
			end
		end
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st <= '0;
		end else if (ce_in) begin
			st <= next_st;
		end
	end

	assign sfr_rdata_out = st.rdata;
	assign busy_out = st.busy;

	// ************************************************************
	// checks
	// ************************************************************
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			run_cnt <= 5'h00;
		end else if (ce_in) begin
			// a restart begins a fresh count, so lengths are measured from the last start
			if (sfr_wr_in && (sfr_addr_in == `MDU_ADDR_BYTE5 || is_ctrl)) begin
				run_cnt <= 5'h00;
			end else begin
				run_cnt <= st.busy ? (run_cnt + 5'h01) : 5'h00;
			end
		end
	end

	default clocking cb @(posedge ref_clk_in);
	endclocking

	default disable iff (rst_in || !ce_in);

	AST_START_ON_LAST_WRITE:
	assert property ((sfr_wr_in && (sfr_addr_in == `MDU_ADDR_BYTE5 || is_ctrl)) |=> st.busy)
	else $error("operation did not start on final write");

	AST_DIV_MUL_LENGTH:
	assert property (($fell(st.busy) && $past(sfr_wr_in) == 1'b0 &&
		(st.op == mdu_pkg::op_div32 || st.op == mdu_pkg::op_div16 || st.op == mdu_pkg::op_mul))
		|-> run_cnt == ((st.op == mdu_pkg::op_div32) ? `MDU_CYC_DIV32 :
		(st.op == mdu_pkg::op_div16) ? `MDU_CYC_DIV16 : `MDU_CYC_MUL))
	else $error("divide or multiply took the wrong number of cycles");

	AST_SHIFT_LENGTH:
	assert property (($fell(st.busy) && st.op == mdu_pkg::op_shift)
		|-> run_cnt == (`MDU_CYC_SHIFT_MIN + ((st.cnt - 5'h01) >> 1)))
	else $error("shift took the wrong number of cycles");

	AST_SELECT_DIV32:
	assert property ((sfr_wr_in && sfr_addr_in == `MDU_ADDR_BYTE5 && st.seen23)
		|=> st.op == mdu_pkg::op_div32 ##10 st.busy)
	else $error("32/16 division not selected or ended early");

	AST_WRITE_DURING_EXEC:
	assert property ((st.busy && sfr_wr_in && (is_md || is_ctrl)) |=> st.err)
	else $error("write during execution did not flag an error");

	AST_READ_DURING_EXEC:
	assert property ((st.busy && st.armed && sfr_rd_in && is_md && !sfr_wr_in && st.left != 5'h00)
		|=> st.err && st.busy)
	else $error("armed read during execution mishandled");

	AST_ERR_CLEAR_ONLY_BY_READ:
	assert property ($fell(st.err) |-> $past(sfr_rd_in) && $past(is_ctrl))
	else $error("error flag cleared without a control read");

	AST_OV_HELD_BY_WRITES:
	assert property ((!st.busy && sfr_wr_in) |=> $stable(st.ov))
	else $error("core write changed the overflow flag");

	AST_NORM_RESULT:
	assert property (($fell(st.busy) && st.op == mdu_pkg::op_norm && st.md[3:0] != 32'h00000000)
		|-> st.md[3][7])
	else $error("normalize left the top bit clear");

	AST_DISARM_ON_LAST_READ:
	assert property ((!st.busy && st.armed && sfr_rd_in && !sfr_wr_in &&
		sfr_addr_in == `MDU_ADDR_BYTE3 && st.op == mdu_pkg::op_mul) |=> !st.armed)
	else $error("final multiply read did not disarm error detection");

	AST_ARM_ON_FIRST_BYTE:
	assert property ((sfr_wr_in && sfr_addr_in == `MDU_ADDR_BYTE0) |=> st.armed)
	else $error("operand byte0 write did not arm error detection");

	AST_DISARM_ON_DIV_READ:
	assert property ((!st.busy && st.armed && sfr_rd_in && !sfr_wr_in &&
		sfr_addr_in == `MDU_ADDR_BYTE5 &&
		(st.op == mdu_pkg::op_div32 || st.op == mdu_pkg::op_div16)) |=> !st.armed)
	else $error("final division read did not disarm error detection");

	AST_SELECT_MUL:
	assert property ((sfr_wr_in && sfr_addr_in == `MDU_ADDR_BYTE5 && !st.seen23 &&
		st.last_mul) |=> st.op == mdu_pkg::op_mul)
	else $error("multiplication not selected");

	AST_SELECT_DIV16:
	assert property ((sfr_wr_in && sfr_addr_in == `MDU_ADDR_BYTE5 && !st.seen23 &&
		!st.last_mul) |=> st.op == mdu_pkg::op_div16)
	else $error("16/16 division not selected");

	AST_DIR_RIGHT:
	assert property ((sfr_wr_in && is_ctrl && sfr_wdata_in[`MDU_CTRL_DIR_BIT]) |=> st.dir)
	else $error("right shift direction not stored");

	AST_DIR_LEFT:
	assert property ((sfr_wr_in && is_ctrl && !sfr_wdata_in[`MDU_CTRL_DIR_BIT]) |=> !st.dir)
	else $error("left shift direction not stored");

	AST_SELECT_NORM:
	assert property ((sfr_wr_in && is_ctrl && sfr_wdata_in[`MDU_CTRL_CNT_MSB:0] == 5'h00)
		|=> st.op == mdu_pkg::op_norm)
	else $error("normalize not selected by a zero count");

	AST_SELECT_SHIFT:
	assert property ((sfr_wr_in && is_ctrl && sfr_wdata_in[`MDU_CTRL_CNT_MSB:0] != 5'h00)
		|=> st.op == mdu_pkg::op_shift)
	else $error("shift not selected by a nonzero count");

	AST_NORM_LENGTH:
	assert property (($fell(st.busy) && st.op == mdu_pkg::op_norm)
		|-> run_cnt >= `MDU_CYC_NORM_MIN && run_cnt <= `MDU_CYC_NORM_MAX)
	else $error("normalize length out of range");

	AST_SHIFT_CLEARS_OV:
	assert property (($fell(st.busy) && st.op == mdu_pkg::op_shift) |-> !st.ov)
	else $error("shift left the overflow flag set");

	AST_MUL_OV:
	assert property (($fell(st.busy) && st.op == mdu_pkg::op_mul && !$past(sfr_wr_in))
		|-> st.ov == (st.md[3:2] != 16'h0000))
	else $error("multiply overflow flag does not match the product");

	AST_ERR_READ_BACK:
	assert property ((sfr_rd_in && is_ctrl)
		|=> sfr_rdata_out[`MDU_CTRL_ERR_BIT] == $past(st.err))
	else $error("control read did not return the error flag");

endmodule // arith_coprocessor

`default_nettype wire

// [testbench/sfr_core_model.sv]
`timescale 1ns/100ps
`default_nettype none

module sfr_core_model (
	input wire logic clk_in,
	output logic [7:0] addr_out,
	output logic wr_out,
	output logic rd_out,
	output logic [7:0] wdata_out,
	input wire logic [7:0] rdata_in
);
	// ************************************************************
	// special function register accesses of the core
	// ************************************************************
	initial begin
		addr_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
		wdata_out = 8'h00;
	end

	// idle lines show the inverse, so a stale address or data byte never passes for a live one
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		#1;
		addr_out = a;
		wdata_out = d;
		wr_out = 1'b1;
		@(posedge clk_in);
		#1;
		wr_out = 1'b0;
		addr_out = ~a;
		wdata_out = ~d;
	endtask

	// read data is registered, so it is taken one step after the sampling edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		#1;
		addr_out = a;
		rd_out = 1'b1;
		@(posedge clk_in);
		#1;
		d = rdata_in;
		rd_out = 1'b0;
		addr_out = ~a;
	endtask
endmodule // sfr_core_model

`default_nettype wire

// [testbench/arith_coprocessor_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "mdu_defines.svh"

module arith_coprocessor_tb;
	logic ref_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic wr;
	logic rd;
	logic busy;
	logic ce = 1'b1;
	int failures = 0;
	int n_checks = 0;
	int cycles = 0;
	localparam logic [7:0] CTRL = `MDU_ADDR_CTRL;

	always #25 ref_clk_in = ~ref_clk_in;

	arith_coprocessor dut (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.ce_in(ce),
		.sfr_addr_in(addr),
		.sfr_wr_in(wr),
		.sfr_rd_in(rd),
		.sfr_wdata_in(wdata),
		.sfr_rdata_out(rdata),
		.busy_out(busy)
	);

	sfr_core_model core (
		.clk_in(ref_clk_in),
		.addr_out(addr),
		.wr_out(wr),
		.rd_out(rd),
		.wdata_out(wdata),
		.rdata_in(rdata)
	);

	// ************************************************************
	// helpers
	// ************************************************************
	task automatic report_and_stop();
		if (failures == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// whole run needs well under a thousand cycles
	always @(posedge ref_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures++;
			report_and_stop();
		end
	end

	function automatic logic [7:0] ba(input int k);
		return `MDU_ADDR_BYTE0 + 8'(k);
	endfunction

	task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_cycles(input string what, input int exp, input int got);
		n_checks++;
		if (got != exp) begin
			failures++;
			$display("[FAIL] %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
		input string what);
		logic [7:0] d;
		core.rd(a, d);
		check8(what, e & m, d & m);
	endtask

	task automatic wait_busy(input int exp, input string what);
		int n;
		n = 0;
		while (busy === 1'b1 && n < 100) begin
			@(posedge ref_clk_in);
			#1;
			n++;
		end
		check_cycles(what, exp, n);
	endtask

	task automatic put(input int first, input logic [31:0] v, input int nb);
		for (int k = 0; k < nb; k++) core.wr(ba(first + k), v[8*k +: 8]);
	endtask

	task automatic get(input int first, input logic [31:0] v, input int nb, input string what);
		for (int k = 0; k < nb; k++) rdchk(ba(first + k), 8'hFF, v[8*k +: 8], what);
	endtask

	// ************************************************************
	// operations; mode 1 reads an operand mid-run, mode 2 restarts it
	// ************************************************************
	task automatic mulop(input logic [15:0] a, input logic [15:0] b, input int mode);
		logic [31:0] p;
		logic [7:0] d;
		p = 32'(a) * 32'(b);
		core.wr(ba(0), a[7:0]);
		core.wr(ba(4), b[7:0]);
		core.wr(ba(1), a[15:8]);
		core.wr(ba(5), b[15:8]);
		if (mode == 1) core.rd(ba(0), d);
		if (mode == 2) core.wr(ba(5), b[15:8]);
		wait_busy(mode == 1 ? 9 : 11, "mul cycles");
		get(0, p, 4, "product");
		rdchk(CTRL, 8'hC0, {mode != 0, p[31:16] != 0, 6'h00}, "mul flags");
	endtask

	task automatic divop(input logic [31:0] n, input logic [15:0] dv, input bit wide);
		logic [31:0] q;
		logic [15:0] r;
		q = dv == 0 ? 32'hFFFFFFFF : n / 32'(dv);
		r = dv == 0 ? n[15:0] : 16'(n % 32'(dv));
		core.wr(ba(0), n[7:0]);
		put(1, n >> 8, wide ? 3 : 1);
		put(4, 32'(dv), 2);
		wait_busy(wide ? 17 : 9, "div cycles");
		get(0, q, wide ? 4 : 2, "quotient");
		get(4, 32'(r), 2, "remainder");
		rdchk(CTRL, 8'hC0, {1'b0, dv == 0, 6'h00}, "div flags");
	endtask

	task automatic shiftop(input logic [31:0] v, input logic [7:0] c);
		logic [31:0] e;
		int lz;
		int n;
		lz = 0;
		if (c[4:0] != 0) begin
			e = c[5] ? v >> c[4:0] : v << c[4:0];
			n = 3 + (int'(c[4:0]) - 1) / 2;
		end else begin
			while (lz < 31 && v[31 - lz] === 1'b0) lz++;
			e = v << lz;
			n = lz == 0 ? 4 : 4 + (lz - 1) / 2;
		end
		put(0, v, 4);
		core.wr(CTRL, c);
		wait_busy(n, "shift cycles");
		get(0, e, 4, "shifted");
		rdchk(CTRL, 8'hFF, {1'b0, c[4:0] == 0 && v[31], c[5],
			c[4:0] == 0 ? 5'(lz) : c[4:0]}, "shift ctrl");
	endtask

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		logic [7:0] d;
		repeat (10) @(posedge ref_clk_in);
		#1;
		rst_in = 1'b0;
		for (int k = 0; k < 7; k++) rdchk(ba(k), 8'hFF, 8'h00, "reset value");
		mulop(16'h1234, 16'h0100, 0);
		mulop(16'hFFFF, 16'hFFFF, 0);
		mulop(16'h0003, 16'h0005, 0);
		mulop(16'h0003, 16'h0005, 1);
		mulop(16'h0007, 16'h0009, 2);
		rdchk(CTRL, 8'h80, 8'h00, "error cleared");
		divop(32'h12345678, 16'h0100, 1'b1);
		divop(32'hFFFFFFFF, 16'h0003, 1'b1);
		divop(32'h00001234, 16'h0010, 1'b0);
		divop(32'h0000ABCD, 16'h0000, 1'b0);
		shiftop(32'h87654321, 8'h04);
		shiftop(32'h87654321, 8'h3F);
		shiftop(32'h00012345, 8'hC1);
		shiftop(32'h00010000, 8'h00);
		shiftop(32'h80000001, 8'h00);
		shiftop(32'h00000000, 8'h00);
		// a low clock enable must freeze the countdown and the operand bytes
		put(0, 32'h00000003, 4);
		core.wr(CTRL, 8'h02);
		ce = 1'b0;
		repeat (4) @(posedge ref_clk_in);
		#1;
		ce = 1'b1;
		wait_busy(3, "frozen shift cycles");
		get(0, 32'h0000000C, 4, "frozen shift");
		// no byte0 write since the last final read, so a mid-run read must not flag
		core.wr(CTRL, 8'h01);
		core.rd(ba(0), d);
		wait_busy(1, "unarmed shift cycles");
		rdchk(CTRL, 8'h80, 8'h00, "unarmed read");
		report_and_stop();
	end
endmodule // arith_coprocessor_tb

`default_nettype wire
